// file: core/qwd_device.sv
// Purpose: Device end: decodes and executes queued DMA writes
// Assumes: Host keeps its own tag and queue-depth rules
// Notes: One command executes at a time; others wait in tag table
`timescale 1ns/1ps
module qwd_device #(
    parameter int QUEUE_DEPTH = 32,
    parameter int FINE_CYCLES = qwd_pkg::FINE_CYCLES
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    qwd_link_if.device link,
    input wire logic write_cache_en_i,
    output logic media_we_o,
    output logic [47:0] media_lba_o,
    output logic [qwd_pkg::DATA_W-1:0] media_data_o,
    input wire logic media_ready_i,
    input wire logic media_error_i,
    output logic busy_o
);
    initial begin
        if (QUEUE_DEPTH < 1 || QUEUE_DEPTH > qwd_pkg::MAX_TAGS || FINE_CYCLES < 1) begin
            $error("QUEUE_DEPTH must be 1..32 and FINE_CYCLES at least 1");
        end
    end
    localparam int COARSE_MULT = qwd_pkg::COARSE_MS / qwd_pkg::FINE_MS;

    typedef enum logic [1:0] {S_IDLE, S_PICK, S_WRITE, S_FINISH} qwd_state_type;
    typedef struct packed {
        logic [47:0] lba;
        logic [16:0] len;
        logic [1:0] priority_level;
        logic [13:0] limit;
        logic fmw;
    } qwd_slot_type;
    typedef struct packed {
        qwd_state_type state;
        logic [31:0] busy_tags;
        logic [31:0] pend_tags;
        logic [4:0] cur;
        logic [47:0] lba;
        logic [16:0] left;
        logic [13:0] elapsed;
        logic [13:0] limit;
        logic [23:0] tick_cnt;
        logic fmw;
        logic done_valid;
        logic [4:0] done_tag;
        logic [7:0] err;
        logic [7:0] cerr;
        logic busy;
        logic [7:0] stat;
        logic [47:0] fail_lba;
        logic [7:0] rb0, rb1, rb2;
        logic we;
        logic [47:0] m_lba;
        logic [qwd_pkg::DATA_W-1:0] m_data;
    } qwd_dev_st_type;

    qwd_dev_st_type st_ff, nxt_st;
    qwd_slot_type slots [qwd_pkg::MAX_TAGS];
    logic slot_we;
    qwd_slot_type slot_new;
    logic f_valid, f_ready;
    logic [qwd_pkg::DATA_W-1:0] f_data;

    // Deadline in 10 ms ticks: coarse codes scale by 50
    function automatic logic [13:0] limit_ticks(input logic [7:0] code);
        logic [13:0] n;
        n = 14'(code[6:0]) + 14'h1;
        if (code[qwd_pkg::DL_COARSE_BIT]) begin
            n = 14'(n * COARSE_MULT);
        end
        return n;
    endfunction

    // Highest urgency pending tag: high, then isochronous, then normal
    function automatic logic [5:0] pick(input logic [31:0] p);
        logic [5:0] r;
        r = 6'h20;
        for (int k = 1; k <= 3; k++) begin
            for (int t = 31; t >= 0; t--) begin
                if (r[5] && p[t] && slots[t].priority_level == (k == 1 ? qwd_pkg::PRIORITY_LEVEL_HIGH :
                    k == 2 ? qwd_pkg::PRIORITY_LEVEL_ISOCH : qwd_pkg::PRIORITY_LEVEL_NORMAL)) begin
                    r = 6'(t);
                end
            end
        end
        return r;
    endfunction

    qwd_fifo #(.WIDTH(qwd_pkg::DATA_W), .DEPTH(qwd_pkg::FIFO_DEPTH)) u_fifo (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .in_valid_i(link.wdata_valid),
        .in_ready_o(link.wdata_ready),
        .in_data_i(link.wdata),
        .out_valid_o(f_valid),
        .out_ready_i(f_ready),
        .out_data_o(f_data)
    );

    always_comb begin
        logic [4:0] tag;
        logic [15:0] len16;
        logic [5:0] p;
        logic [47:0] flba;
        tag = link.cmd.count_cur[qwd_pkg::TAG_HI:qwd_pkg::TAG_LO];
        len16 = {link.cmd.feat_prev, link.cmd.feat_cur};
        p = pick(st_ff.pend_tags);
        flba = st_ff.fail_lba;
        nxt_st = st_ff;
        nxt_st.done_valid = 1'b0;
        nxt_st.we = 1'b0;
        slot_we = 1'b0;
        f_ready = 1'b0;
        slot_new.lba = {link.cmd.lba5, link.cmd.lba4, link.cmd.lba3,
                        link.cmd.lba2, link.cmd.lba1, link.cmd.lba0};
        slot_new.len = (len16 == 16'h0) ? 17'h10000 : {1'b0, len16};
        slot_new.priority_level = link.cmd.count_prev[qwd_pkg::PRIORITY_LEVEL_HI:qwd_pkg::PRIORITY_LEVEL_LO];
        slot_new.limit = (slot_new.priority_level == qwd_pkg::PRIORITY_LEVEL_ISOCH) ?
                         limit_ticks(link.cmd.count_cur) : 14'h0;
        slot_new.fmw = link.cmd.dev_head[qwd_pkg::FMW_BIT];
        if (link.cmd_valid && link.cmd.opcode == qwd_pkg::CMD_QUEUED_WRITE) begin
            if (st_ff.busy_tags[tag] || 32'(tag) >= QUEUE_DEPTH) begin
                nxt_st.done_valid = 1'b1;
                nxt_st.done_tag = tag;
                nxt_st.err = 8'h1 << qwd_pkg::ERR_ABT;
                nxt_st.stat = qwd_pkg::ST_IDLE | (8'h1 << qwd_pkg::ST_ERR);
            end else begin
                slot_we = 1'b1;
                nxt_st.busy_tags[tag] = 1'b1;
                nxt_st.pend_tags[tag] = 1'b1;
            end
        end
        if (st_ff.state != S_IDLE && st_ff.state != S_PICK) begin
            if (st_ff.tick_cnt == 24'(FINE_CYCLES - 1)) begin
                nxt_st.tick_cnt = '0;
                if (st_ff.elapsed != 14'h3fff) begin
                    nxt_st.elapsed = st_ff.elapsed + 14'h1;
                end
            end else begin
                nxt_st.tick_cnt = st_ff.tick_cnt + 24'h1;
            end
        end
        case (st_ff.state)
            S_IDLE: begin
                if (st_ff.pend_tags != '0) begin
                    nxt_st.state = S_PICK;
                end
            end
            S_PICK: begin
                nxt_st.cur = p[4:0];
                nxt_st.pend_tags[p[4:0]] = 1'b0;
                nxt_st.lba = slots[p[4:0]].lba;
                nxt_st.left = slots[p[4:0]].len;
                nxt_st.limit = slots[p[4:0]].limit;
                nxt_st.fmw = slots[p[4:0]].fmw;
                nxt_st.elapsed = '0;
                nxt_st.tick_cnt = '0;
                nxt_st.cerr = '0;
                nxt_st.stat = qwd_pkg::ST_IDLE | (8'h1 << qwd_pkg::ST_DRQ);
                nxt_st.state = S_WRITE;
            end
            S_WRITE: begin
                if (link.dl_abort_en && st_ff.limit != '0 &&
                    st_ff.elapsed >= st_ff.limit) begin
                    nxt_st.cerr = 8'h1 << qwd_pkg::ERR_ABT;
                    nxt_st.state = S_FINISH;
                end else if (media_error_i) begin
                    // Sector writes stop here; remaining data is left in the FIFO
                    nxt_st.cerr = (8'h1 << qwd_pkg::ERR_UNC) | (8'h1 << qwd_pkg::ERR_IDN);
                    flba = st_ff.lba;
                    nxt_st.fail_lba = flba;
                    nxt_st.state = S_FINISH;
                end else if (st_ff.left == '0) begin
                    // Without write cache, or when forced, wait for the media to settle
                    if (!st_ff.fmw && write_cache_en_i) begin
                        nxt_st.state = S_FINISH;
                    end else if (media_ready_i) begin
                        nxt_st.state = S_FINISH;
                    end
                end else if (f_valid && media_ready_i) begin
                    f_ready = 1'b1;
                    nxt_st.we = 1'b1;
                    nxt_st.m_lba = st_ff.lba;
                    nxt_st.m_data = f_data;
                    nxt_st.lba = st_ff.lba + 48'h1;
                    nxt_st.left = st_ff.left - 17'h1;
                end
            end
            S_FINISH: begin
                // A tag refusal owns the completion port this cycle; finish one later
                if (!nxt_st.done_valid) begin
                    nxt_st.done_valid = 1'b1;
                    nxt_st.done_tag = st_ff.cur;
                    nxt_st.busy_tags[st_ff.cur] = 1'b0;
                    nxt_st.err = st_ff.cerr;
                    nxt_st.stat = qwd_pkg::ST_IDLE |
                                  ((st_ff.cerr != '0) ? 8'h1 << qwd_pkg::ST_ERR : 8'h0);
                    nxt_st.state = S_IDLE;
                end
            end
            default: nxt_st.state = S_IDLE;
        endcase
        nxt_st.rb0 = link.high_byte_readback ? flba[31:24] : flba[7:0];
        nxt_st.rb1 = link.high_byte_readback ? flba[39:32] : flba[15:8];
        nxt_st.rb2 = link.high_byte_readback ? flba[47:40] : flba[23:16];
        nxt_st.busy = (nxt_st.state != S_IDLE);
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st_ff <= '0;
            st_ff.stat <= qwd_pkg::ST_IDLE;
        end else begin
            st_ff <= nxt_st;
        end
    end

    always_ff @(posedge clk_i) begin
        if (slot_we) begin
            slots[link.cmd.count_cur[qwd_pkg::TAG_HI:qwd_pkg::TAG_LO]] <= slot_new;
        end
    end

    assign link.done_valid = st_ff.done_valid;
    assign link.done_tag = st_ff.done_tag;
    assign link.error_flags = st_ff.err;
    assign link.completion_flags = st_ff.stat;
    assign link.rb_lba0 = st_ff.rb0;
    assign link.rb_lba1 = st_ff.rb1;
    assign link.rb_lba2 = st_ff.rb2;
    assign media_we_o = st_ff.we;
    assign media_lba_o = st_ff.m_lba;
    assign media_data_o = st_ff.m_data;
    assign busy_o = st_ff.busy;
endmodule // qwd_device

// file: core/qwd_fifo.sv
// Purpose: Small synchronous FIFO for write data
// Assumes: One clock, asynchronous active-low reset
// Notes: Full and empty are exact; no bypass path
`timescale 1ns/1ps
module qwd_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH) begin
            $error("DEPTH must be a power of two, at least 2");
        end
    end
    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } qwd_fifo_st_type;
    qwd_fifo_st_type st_ff, nxt_st;
    logic [WIDTH-1:0] mem [DEPTH];
    logic push, pop;

    assign in_ready_o = (st_ff.cnt != (AW+1)'(DEPTH));
    assign out_valid_o = (st_ff.cnt != '0);
    assign out_data_o = mem[st_ff.rp];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    always_comb begin
        nxt_st = st_ff;
        if (push) begin
            nxt_st.wp = st_ff.wp + 1'b1;
        end
        if (pop) begin
            nxt_st.rp = st_ff.rp + 1'b1;
        end
        if (push && !pop) begin
            nxt_st.cnt = st_ff.cnt + 1'b1;
        end else if (pop && !push) begin
            nxt_st.cnt = st_ff.cnt - 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Storage has no reset so it maps onto plain RAM
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[st_ff.wp] <= in_data_i;
        end
    end
endmodule // qwd_fifo

// file: core/qwd_host.sv
// Purpose: Host end: issues queued writes and streams their data
// Assumes: User holds request until accepted
// Notes: Tags handed out from a free mask, never beyond depth
`timescale 1ns/1ps
module qwd_host #(
    parameter int QUEUE_DEPTH = 32
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    qwd_link_if.host link,
    input wire logic req_i,
    input wire logic [15:0] req_len_i,
    input wire logic [47:0] req_lba_i,
    input wire logic [1:0] req_priority_level_i,
    input wire logic [7:0] req_deadline_i,
    input wire logic req_fmw_i,
    output logic req_ack_o,
    input wire logic data_valid_i,
    input wire logic [qwd_pkg::DATA_W-1:0] data_i,
    output logic data_ready_o,
    input wire logic hob_i,
    input wire logic dl_abort_en_i,
    output logic done_o,
    output logic [4:0] done_tag_o,
    output logic [7:0] done_err_o
);
    initial begin
        if (QUEUE_DEPTH < 1 || QUEUE_DEPTH > qwd_pkg::MAX_TAGS) begin
            $error("QUEUE_DEPTH must be 1..32");
        end
    end
    typedef struct packed {
        logic [31:0] used;
        logic ack;
        logic done;
        logic [4:0] dtag;
        logic [7:0] derr;
    } qwd_host_st_type;
    qwd_host_st_type st_ff, nxt_st;
    logic [5:0] free_tag;

    always_comb begin
        free_tag = 6'h20;
        for (int t = QUEUE_DEPTH - 1; t >= 0; t--) begin
            if (!st_ff.used[t]) begin
                free_tag = 6'(t);
            end
        end
    end

    always_comb begin
        link.cmd = '0;
        link.cmd.opcode = qwd_pkg::CMD_QUEUED_WRITE;
        link.cmd.feat_cur = req_len_i[7:0];
        link.cmd.feat_prev = req_len_i[15:8];
        link.cmd.count_cur = {free_tag[4:0], 3'h0};
        link.cmd.count_prev = {req_priority_level_i, 6'h0};
        link.cmd.lba0 = req_lba_i[7:0];
        link.cmd.lba1 = req_lba_i[15:8];
        link.cmd.lba2 = req_lba_i[23:16];
        link.cmd.lba3 = req_lba_i[31:24];
        link.cmd.lba4 = req_lba_i[39:32];
        link.cmd.lba5 = req_lba_i[47:40];
        link.cmd.dev_head = {req_fmw_i, 7'h40};
        // Tag byte's low bits stay zero; the deadline code is not carried in the command
        link.cmd.count_cur[2:0] = 3'h0;
        link.cmd_tag = free_tag[4:0];
        link.cmd_valid = req_i && !st_ff.ack && !free_tag[5];
    end

    always_comb begin
        nxt_st = st_ff;
        nxt_st.ack = link.cmd_valid;
        nxt_st.done = link.done_valid;
        if (link.done_valid) begin
            nxt_st.dtag = link.done_tag;
            nxt_st.derr = link.error_flags;
            nxt_st.used[link.done_tag] = 1'b0;
        end
        if (link.cmd_valid) begin
            nxt_st.used[free_tag[4:0]] = 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign link.wdata_valid = data_valid_i;
    assign link.wdata = data_i;
    assign data_ready_o = link.wdata_ready;
    assign link.high_byte_readback = hob_i;
    assign link.dl_abort_en = dl_abort_en_i;
    assign req_ack_o = st_ff.ack;
    assign done_o = st_ff.done;
    assign done_tag_o = st_ff.dtag;
    assign done_err_o = st_ff.derr;
endmodule // qwd_host

// file: core/qwd_link_if.sv
// Purpose: Carrier between host end and device end
// Assumes: Single clock, both ends synchronous to clk
// Notes: Data words flow host to device with valid/ready
`timescale 1ns/1ps
interface qwd_link_if;
    logic cmd_valid;
    qwd_pkg::qwd_cmd_type cmd;
    logic [4:0] cmd_tag;
    logic wdata_valid;
    logic wdata_ready;
    logic [qwd_pkg::DATA_W-1:0] wdata;
    logic done_valid;
    logic [4:0] done_tag;
    logic [7:0] error_flags;
    logic [7:0] completion_flags;
    logic high_byte_readback;
    logic [7:0] rb_lba0;
    logic [7:0] rb_lba1;
    logic [7:0] rb_lba2;
    logic dl_abort_en;
    modport host (output cmd_valid, cmd, cmd_tag, wdata_valid, wdata, high_byte_readback,
                  dl_abort_en, input wdata_ready, done_valid, done_tag, error_flags,
                  completion_flags, rb_lba0, rb_lba1, rb_lba2);
    modport device (input cmd_valid, cmd, cmd_tag, wdata_valid, wdata, high_byte_readback,
                    dl_abort_en, output wdata_ready, done_valid, done_tag, error_flags,
                    completion_flags, rb_lba0, rb_lba1, rb_lba2);
endinterface // qwd_link_if

// file: core/qwd_pkg.sv
// Purpose: Shared constants and types for the queued write command decoder
// Assumes: One 25 MHz core clock on both ends
// Notes: Register bytes are 8 bits; all field positions are named here
package qwd_pkg;
    localparam logic [7:0] CMD_QUEUED_WRITE = 8'h61;
    localparam int CLK_HZ = 25000000;
    localparam int FINE_MS = 10;
    localparam int COARSE_MS = 500;
    localparam int FINE_CYCLES = (CLK_HZ / 1000) * FINE_MS;
    localparam int COARSE_CYCLES = (CLK_HZ / 1000) * COARSE_MS;
    localparam int TAG_HI = 7;
    localparam int TAG_LO = 3;
    localparam int PRIORITY_LEVEL_HI = 7;
    localparam int PRIORITY_LEVEL_LO = 6;
    localparam int DL_COARSE_BIT = 7;
    localparam int FMW_BIT = 7;
    localparam int MAX_TAGS = 32;
    localparam logic [1:0] PRIORITY_LEVEL_NORMAL = 2'h0;
    localparam logic [1:0] PRIORITY_LEVEL_ISOCH = 2'h1;
    localparam logic [1:0] PRIORITY_LEVEL_HIGH = 2'h2;
    // Error flag positions
    localparam int ERR_UNC = 6;
    localparam int ERR_IDN = 4;
    localparam int ERR_ABT = 2;
    // Completion flag positions
    localparam int ST_RDY = 6;
    localparam int ST_DF = 5;
    localparam int ST_DSC = 4;
    localparam int ST_DRQ = 3;
    localparam int ST_ERR = 0;
    localparam logic [7:0] ST_IDLE = 8'h50;
    localparam int DATA_W = 16;
    localparam int FIFO_DEPTH = 8;

    typedef struct packed {
        logic [7:0] feat_cur;
        logic [7:0] feat_prev;
        logic [7:0] count_cur;
        logic [7:0] count_prev;
        logic [7:0] lba0;
        logic [7:0] lba1;
        logic [7:0] lba2;
        logic [7:0] lba3;
        logic [7:0] lba4;
        logic [7:0] lba5;
        logic [7:0] dev_head;
        logic [7:0] opcode;
    } qwd_cmd_type;
endpackage

// file: sim/queued_write_command_decoder_bench.sv
// Purpose: Self-checking bench, host end facing device end
// Assumes: Deadline tick shortened to 4 cycles, queue depth 4
// Notes: Media stalls are made by holding media_ready low
`timescale 1ns/1ps
module queued_write_command_decoder_bench;
    logic clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic media_ready = 1'b0, media_error = 1'b0, cache_en = 1'b1;
    logic req = 1'b0, req_fmw = 1'b0, data_valid = 1'b0, high_sel = 1'b0, dl_abort_en = 1'b0;
    logic [15:0] req_len = 16'h0, data = 16'h0, media_data;
    logic [47:0] req_lba = 48'h0, media_lba;
    logic [1:0] req_level = 2'h0;
    logic req_ack, data_ready, done, media_we, busy;
    logic [4:0] done_tag, cap_tag;
    logic [7:0] done_err;
    logic refused = 1'b0;
    int fail_count = 0, num_checks = 0, cycles = 0, acc = 0;
    logic [47:0] wlba [$];
    logic [15:0] wdat [$];
    qwd_pkg::qwd_cmd_type cap_cmd;

    always #20 clk_i = ~clk_i;

    qwd_link_if qwd_link_if_inst ();
    qwd_host #(.QUEUE_DEPTH(4)) qwd_host_inst (.clk_i(clk_i), .resetn_i(resetn_i),
        .link(qwd_link_if_inst), .req_i(req), .req_len_i(req_len), .req_lba_i(req_lba),
        .req_priority_level_i(req_level), .req_deadline_i(8'h00), .req_fmw_i(req_fmw),
        .req_ack_o(req_ack), .data_valid_i(data_valid), .data_i(data),
        .data_ready_o(data_ready), .hob_i(high_sel), .dl_abort_en_i(dl_abort_en),
        .done_o(done), .done_tag_o(done_tag), .done_err_o(done_err));
    qwd_device #(.QUEUE_DEPTH(4), .FINE_CYCLES(4)) qwd_device_inst (.clk_i(clk_i),
        .resetn_i(resetn_i), .link(qwd_link_if_inst), .write_cache_en_i(cache_en),
        .media_we_o(media_we), .media_lba_o(media_lba), .media_data_o(media_data),
        .media_ready_i(media_ready), .media_error_i(media_error), .busy_o(busy));
    qwd_link_chk #(.QUEUE_DEPTH(4)) qwd_link_chk_inst (.clk_i(clk_i), .resetn_i(resetn_i),
        .cmd_valid(qwd_link_if_inst.cmd_valid), .cmd(qwd_link_if_inst.cmd),
        .cmd_tag(qwd_link_if_inst.cmd_tag), .done_valid(qwd_link_if_inst.done_valid),
        .done_tag(qwd_link_if_inst.done_tag), .error_flags(qwd_link_if_inst.error_flags),
        .completion_flags(qwd_link_if_inst.completion_flags),
        .dl_abort_en(qwd_link_if_inst.dl_abort_en));

    task automatic results;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Wire capture and media log; a hang ends the run as a mismatch
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (qwd_link_if_inst.cmd_valid === 1'b1) begin
            cap_cmd <= qwd_link_if_inst.cmd;
            cap_tag <= qwd_link_if_inst.cmd_tag;
        end
        if (media_we === 1'b1) begin
            wlba.push_back(media_lba);
            wdat.push_back(media_data);
        end
        if (cycles == 40000) begin
            fail_count++;
            results();
        end
    end

    task automatic send(input logic [15:0] len, input logic [47:0] lba, input logic [1:0] lvl,
                        input logic fmw);
        int n;
        n = 0;
        req_len <= len;
        req_lba <= lba;
        req_level <= lvl;
        req_fmw <= fmw;
        req <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
        end while (req_ack !== 1'b1 && n < 50);
        req <= 1'b0;
        check("ack", 48'(n < 50), 48'h1);
        check("opcode", 48'(cap_cmd.opcode), 48'h61);
        check("length", 48'({cap_cmd.feat_prev, cap_cmd.feat_cur}), 48'(len));
        check("tag field", 48'(cap_cmd.count_cur[7:3]), 48'(cap_tag));
        check("priority", 48'(cap_cmd.count_prev[7:6]), 48'(lvl));
        check("address", {cap_cmd.lba5, cap_cmd.lba4, cap_cmd.lba3, cap_cmd.lba2,
            cap_cmd.lba1, cap_cmd.lba0}, lba);
        check("force flag", 48'(cap_cmd.dev_head[qwd_pkg::FMW_BIT]), 48'(fmw));
    endtask

    task automatic push(input logic [15:0] w);
        int n;
        n = 0;
        data_valid <= 1'b1;
        data <= w;
        do begin
            @(posedge clk_i);
            n++;
            if (data_ready !== 1'b1) refused = 1'b1;
        end while (data_ready !== 1'b1 && n < 400);
        if (!refused) acc++;
        check("word taken", 48'(n < 400), 48'h1);
    endtask

    task automatic wait_done(input logic [7:0] err);
        int n;
        n = 0;
        data_valid <= 1'b0;
        do begin
            @(posedge clk_i);
            n++;
        end while (done !== 1'b1 && n < 2000);
        check("done tag", 48'(done_tag), 48'(cap_tag));
        check("done flags", 48'(done_err), 48'(err));
        check("idle after done", 48'(busy), 48'h0);
    endtask

    initial begin
        repeat (16) @(posedge clk_i);
        resetn_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        check("idle status", 48'(qwd_link_if_inst.completion_flags), 48'h50);
        check("idle errors", 48'(qwd_link_if_inst.error_flags), 48'h0);
        // Media stalled so the buffer fills and refuses before draining
        send(16'h000a, 48'h0a0b0c0d0e0f, qwd_pkg::PRIORITY_LEVEL_NORMAL, 1'b1);
        fork begin repeat (60) @(posedge clk_i); media_ready <= 1'b1; end join_none
        for (int i = 0; i < 10; i++) begin
            push(16'h1000 + 16'(i));
        end
        wait_done(8'h00);
        check("refused", 48'(refused), 48'h1);
        check("depth", 48'(acc >= qwd_pkg::FIFO_DEPTH), 48'h1);
        check("writes before done", 48'(wlba.size()), 48'ha);
        for (int i = 0; i < 10 && i < wlba.size(); i++) begin
            check("media lba", wlba[i], 48'h0a0b0c0d0e0f + 48'(i));
            check("media data", 48'(wdat[i]), 48'(16'h1000 + 16'(i)));
        end
        for (int p = 0; p < 3; p++) begin
            wlba.delete();
            send(16'h0001, 48'h100 + 48'(p), 2'(p), 1'(p != 1));
            push(16'h2000);
            wait_done(8'h00);
            check("one write", 48'(wlba.size()), 48'h1);
        end
        // Failing first sector: nothing written, its address read back
        wlba.delete();
        media_error <= 1'b1;
        send(16'h0002, 48'h665544332211, qwd_pkg::PRIORITY_LEVEL_HIGH, 1'b1);
        push(16'h3000);
        push(16'h3001);
        wait_done(8'h50);
        media_error <= 1'b0;
        check("no write after error", 48'(wlba.size()), 48'h0);
        for (int h = 0; h < 2; h++) begin
            high_sel <= 1'(h);
            repeat (3) @(posedge clk_i);
            check("readback", {24'h0, qwd_link_if_inst.rb_lba2, qwd_link_if_inst.rb_lba1,
                qwd_link_if_inst.rb_lba0}, h == 1 ? 48'h665544 : 48'h332211);
        end
        // Slow media past the deadline, with and without the abort option
        media_ready <= 1'b0;
        for (int k = 0; k < 3; k++) begin
            dl_abort_en <= (k == 2);
            send(16'h0001, 48'h200, k == 1 ? qwd_pkg::PRIORITY_LEVEL_NORMAL : qwd_pkg::PRIORITY_LEVEL_ISOCH, 1'b1);
            fork begin repeat (40) @(posedge clk_i); media_ready <= 1'b1; end join_none
            push(16'h4000);
            wait_done(k == 2 ? 8'h04 : 8'h00);
            media_ready <= 1'b0;
        end
        results();
    end
endmodule // queued_write_command_decoder_bench

// file: sim/qwd_link_chk.sv
// Purpose: Link checks between host end and device end
// Assumes: Both ends on clk_i with async active-low reset
// Notes: Tag and priority tables mirror the commands in flight
`timescale 1ns/1ps
module qwd_link_chk #(
    parameter int QUEUE_DEPTH = 32
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic cmd_valid,
    input wire qwd_pkg::qwd_cmd_type cmd,
    input wire logic [4:0] cmd_tag,
    input wire logic done_valid,
    input wire logic [4:0] done_tag,
    input wire logic [7:0] error_flags,
    input wire logic [7:0] completion_flags,
    input wire logic dl_abort_en
);
    logic [31:0] busy_ff;
    logic [31:0][1:0] level_ff;

    // Completion frees the tag before a new command may claim it again
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            busy_ff <= 32'h0;
            level_ff <= 64'h0;
        end else begin
            if (done_valid) begin
                busy_ff[done_tag] <= 1'b0;
            end
            if (cmd_valid) begin
                busy_ff[cmd_tag] <= 1'b1;
                level_ff[cmd_tag] <= cmd.count_prev[7:6];
            end
        end
    end

    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    sequence s_cmd_once;
        cmd_valid ##1 !cmd_valid;
    endsequence

    chk_opcode_sent: assert property (
        cmd_valid |-> cmd.opcode == qwd_pkg::CMD_QUEUED_WRITE)
        else $error("command opcode wrong");
    chk_cmd_spacing: assert property (
        cmd_valid |-> s_cmd_once)
        else $error("commands closer than two cycles");
    chk_tag_field: assert property (
        cmd_valid |-> cmd.count_cur[7:3] == cmd_tag)
        else $error("tag not in count byte");
    chk_tag_unique: assert property (
        cmd_valid |-> !busy_ff[cmd_tag])
        else $error("tag reused while in flight");
    chk_done_inflight: assert property (
        done_valid |-> busy_ff[done_tag])
        else $error("completion for idle tag");
    chk_tag_depth: assert property (
        cmd_valid |-> cmd_tag < QUEUE_DEPTH)
        else $error("tag beyond queue depth");
    chk_level_code: assert property (
        cmd_valid |-> cmd.count_prev[7:6] != 2'h3)
        else $error("reserved priority code");
    chk_abort_enabled: assert property (
        done_valid && error_flags[qwd_pkg::ERR_ABT] |-> dl_abort_en)
        else $error("abort without abort option");
    chk_abort_isoch: assert property (
        done_valid && error_flags[qwd_pkg::ERR_ABT] |-> level_ff[done_tag] == qwd_pkg::PRIORITY_LEVEL_ISOCH)
        else $error("deadline abort on non-isochronous command");
    chk_ok_status: assert property (
        done_valid && error_flags == 8'h0 |-> completion_flags == qwd_pkg::ST_IDLE)
        else $error("good completion status wrong");
    chk_err_status: assert property (
        done_valid && error_flags != 8'h0 |-> completion_flags[qwd_pkg::ST_ERR])
        else $error("error completion without error bit");
endmodule // qwd_link_chk
